//--- bench/spc_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// Register host model
// ----------------------------------------
module spc_host (
	input  wire logic        clk,
	output logic      [7:0]  addr,
	output logic      [31:0] wdata,
	output logic             wr,
	output logic             rd,
	input  wire logic [31:0] rdata
);
	// Bus idle from time zero
	initial
	begin
		addr = 8'h00;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
	end
	// One-cycle write; data scrambled after release so no stale value lingers
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		wdata <= ~d;
	endtask : wr_reg
	// One-cycle read; data taken in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg
endmodule : spc_host

//--- bench/spc_sector_protect_tb.sv
`timescale 1ns/1ps
// ----------------------------------------
// Sector protection bench
// ----------------------------------------
module spc_sector_protect_tb;
	import spc_pkg::*;
	logic        clk, rstn, nv_init_n, wr, rd;   // Clock, resets, strobes
	logic        pe_req, bp_protect, pe_ack, pe_protect; // Engine query
	logic [6:0]  pe_sector;                      // Queried sector
	logic [7:0]  addr;                           // Register address
	logic [31:0] wdata, rdata, v;                // Bus data
	int          failures, total_checks;         // Counters
	spc_host host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	spc_sector_protect #(.NSEC(128), .UNLOCK_CYC(20), .PROG_CYC(5), .ERASE_CYC(10)) DUT (
		.clk(clk), .rstn(rstn), .nv_init_n(nv_init_n), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .pe_req(pe_req), .pe_sector(pe_sector),
		.bp_protect(bp_protect), .pe_ack(pe_ack), .pe_protect(pe_protect));
	// Free-running 50 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic end_sim;
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		host.rd_reg(a, v);
		chk(v, exp);
	endtask : rdchk
	task automatic cmd(input spc_cmd_t op, input logic [6:0] s);
		host.wr_reg(8'h04, {17'h0, s, 4'h0, op});
	endtask : cmd
	// Bounded poll of the busy flag
	task automatic idle;
		for (int i = 0; i < 100; i++)
		begin
			host.rd_reg(8'h00, v);
			if (v[0] === 1'b0)
				return;
		end
		failures++;
		end_sim();
	endtask : idle
	// Engine query: answer exactly one cycle later
	task automatic query(input logic [6:0] s, input logic bp, input logic exp);
		@(posedge clk);
		pe_req <= 1'b1;
		pe_sector <= s;
		bp_protect <= bp;
		@(posedge clk);
		pe_req <= 1'b0;
		#1 chk({pe_ack, pe_protect}, {1'b1, exp});
	endtask : query
	task automatic do_reset;
		@(posedge clk);
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
	endtask : do_reset
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		rstn = 1'b0;
		nv_init_n = 1'b0;
		pe_req = 1'b0;
		pe_sector = 7'h0;
		bp_protect = 1'b0;
		repeat (3) @(posedge clk);
		nv_init_n <= 1'b1;
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		// Blank part: boot mode, lock set, nothing protected
		rdchk(8'h10, 32'h3);
		rdchk(8'h14, 32'h1);
		query(7'h00, 1'b0, 1'b0);
		query(7'h00, 1'b1, 1'b1);
		$display("test reset done");
		// Persistent bit program, needs write enable
		cmd(CMD_BIT_PROG, 7'h03);
		rdchk(8'h00, 32'h0);
		cmd(CMD_WEN, 7'h0);
		cmd(CMD_BIT_PROG, 7'h03);
		rdchk(8'h00, 32'h1);
		idle();
		cmd(CMD_BIT_READ, 7'h03);
		idle();
		rdchk(8'h18, 32'h0);
		query(7'h03, 1'b0, 1'b1);
		query(7'h04, 1'b0, 1'b0);
		// Volatile bit set and clear
		host.wr_reg(8'h08, 32'h0);
		cmd(CMD_VOL_WR, 7'h05);
		query(7'h05, 1'b0, 1'b1);
		host.wr_reg(8'h08, 32'h1);
		cmd(CMD_VOL_WR, 7'h05);
		query(7'h05, 1'b0, 1'b0);
		host.wr_reg(8'h08, 32'h0);
		cmd(CMD_VOL_WR, 7'h05);
		do_reset();
		query(7'h05, 1'b0, 1'b0);
		query(7'h03, 1'b0, 1'b1);
		$display("test bits done");
		// Erase all persistent bits
		cmd(CMD_WEN, 7'h0);
		cmd(CMD_BIT_ERAS, 7'h0);
		rdchk(8'h00, 32'h1);
		idle();
		cmd(CMD_BIT_READ, 7'h03);
		idle();
		rdchk(8'h18, 32'h1);
		// Lock clear, then bit program refused, volatile write still taken
		cmd(CMD_LOCK_CLR, 7'h0);
		rdchk(8'h14, 32'h0);
		cmd(CMD_WEN, 7'h0);
		cmd(CMD_BIT_PROG, 7'h06);
		rdchk(8'h00, 32'h41);
		cmd(CMD_CLR_STAT, 7'h0);
		rdchk(8'h00, 32'h0);
		query(7'h06, 1'b0, 1'b0);
		cmd(CMD_VOL_WR, 7'h06);
		query(7'h06, 1'b0, 1'b1);
		do_reset();
		rdchk(8'h14, 32'h1);
		$display("test lock done");
		// Illegal mode, then password mode
		cmd(CMD_WEN, 7'h0);
		cmd(CMD_MODE, 7'h0);
		rdchk(8'h00, 32'h41);
		rdchk(8'h10, 32'h3);
		cmd(CMD_CLR_STAT, 7'h0);
		host.wr_reg(8'h08, 32'h1357_9BDF);
		host.wr_reg(8'h0C, 32'h2468_ACE0);
		cmd(CMD_WEN, 7'h0);
		cmd(CMD_PWD, 7'h0);
		idle();
		host.wr_reg(8'h08, 32'h1);
		cmd(CMD_WEN, 7'h0);
		cmd(CMD_MODE, 7'h0);
		rdchk(8'h00, 32'h1);
		idle();
		rdchk(8'h10, 32'h1);
		cmd(CMD_WEN, 7'h0);
		cmd(CMD_CFG, 7'h0);
		rdchk(8'h00, 32'h41);
		cmd(CMD_CLR_STAT, 7'h0);
		do_reset();
		rdchk(8'h14, 32'h0);
		// Wrong unlock: error, penalty, lock stays clear
		host.wr_reg(8'h08, 32'h0);
		cmd(CMD_UNLOCK, 7'h0);
		rdchk(8'h00, 32'h41);
		cmd(CMD_CLR_STAT, 7'h0);
		rdchk(8'h00, 32'h41);
		rdchk(8'h14, 32'h0);
		repeat (25) @(posedge clk);
		cmd(CMD_CLR_STAT, 7'h0);
		rdchk(8'h00, 32'h0);
		// Correct unlock is immediate; reset cleared both operand words
		host.wr_reg(8'h08, 32'h1357_9BDF);
		host.wr_reg(8'h0C, 32'h2468_ACE0);
		cmd(CMD_UNLOCK, 7'h0);
		rdchk(8'h00, 32'h0);
		rdchk(8'h14, 32'h1);
		$display("test mode done");
		// Fresh part again, boot mode fixed for good
		@(posedge clk);
		nv_init_n <= 1'b0;
		@(posedge clk);
		nv_init_n <= 1'b1;
		do_reset();
		query(7'h03, 1'b0, 1'b0);
		host.wr_reg(8'h08, 32'h2);
		cmd(CMD_WEN, 7'h0);
		cmd(CMD_MODE, 7'h0);
		idle();
		rdchk(8'h10, 32'h2);
		do_reset();
		rdchk(8'h14, 32'h1);
		cmd(CMD_WEN, 7'h0);
		cmd(CMD_PWD, 7'h0);
		rdchk(8'h00, 32'h41);
		$display("test boot done");
		end_sim();
	end
endmodule : spc_sector_protect_tb

//--- design/spc_nv_if.sv
`timescale 1ns/1ps
// ----------------------------------------
// Control to non-volatile store link
// ----------------------------------------
interface spc_nv_if
	import spc_pkg::*;
#(
	parameter int NSEC = 128,
	parameter int SW   = 7
);
	logic            start;    // Operation request pulse
	spc_nvop_t       op;       // Operation kind
	logic [SW-1:0]   sector;   // Target sector
	logic [63:0]     wdata;    // Operand
	logic            busy;     // Store working
	logic            done;     // Operation finished pulse
	logic [NSEC-1:0] persist;  // Persistent sector bits
	logic [1:0]      mode;     // Protection mode register
	logic [63:0]     pwd;      // Hidden password
	logic [31:0]     cfg;      // Non-volatile config one to four
	logic [7:0]      learn;    // Non-volatile learning pattern
	modport ctl (output start, op, sector, wdata,
		input busy, done, persist, mode, pwd, cfg, learn);
	modport store (input start, op, sector, wdata,
		output busy, done, persist, mode, pwd, cfg, learn);
endinterface : spc_nv_if

//--- design/spc_nv_store.sv
`timescale 1ns/1ps
`include "spc_params.svh"
// ----------------------------------------
// Non-volatile protection store
// ----------------------------------------
module spc_nv_store
	import spc_pkg::*;
#(
	parameter int NSEC      = 128,
	parameter int SW        = 7,
	parameter int PROG_CYC  = `SPC_PROG_CYC,
	parameter int ERASE_CYC = `SPC_ERASE_CYC
)(
	input wire logic clk,
	input wire logic rstn,
	input wire logic nv_init_n,
	spc_nv_if.store  nv
);
	localparam int CW = $clog2(PROG_CYC + ERASE_CYC + 1);
	spc_nst_t      st;      // Store state
	logic [CW-1:0] cnt;     // Phase countdown
	logic          last;    // Final cycle of a phase
	spc_nvop_t     op_q;    // Latched operation
	logic [SW-1:0] sec_q;   // Latched sector
	logic [63:0]   data_q;  // Latched operand

	assign last    = (cnt == '0);
	assign nv.busy = (st != SN_IDLE);
	assign nv.done = last && ((st == SN_PROG) || (st == SN_ERASE));

	// Sequencer; erase is preprogram, verify, then erase
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			st  <= SN_IDLE;
			cnt <= '0;
		end
		else
			case (st)
			SN_IDLE:
				if (nv.start)
				begin
					st  <= (nv.op == NV_ERASE) ? SN_PREP : SN_PROG;
					cnt <= CW'(PROG_CYC - 1);
				end
			SN_PROG:
				if (last) st <= SN_IDLE;
				else cnt <= cnt - 1'b1;
			SN_PREP:
				if (!last) cnt <= cnt - 1'b1;
				else if (~|nv.persist)
				begin
					// Verified all programmed; erase may start
					st  <= SN_ERASE;
					cnt <= CW'(ERASE_CYC - 1);
				end
				else cnt <= CW'(PROG_CYC - 1);
			SN_ERASE:
				if (last) st <= SN_IDLE;
				else cnt <= cnt - 1'b1;
			default: st <= SN_IDLE;
			endcase

	// Operand capture at start
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			op_q   <= NV_MODE;
			sec_q  <= '0;
			data_q <= '0;
		end
		else if (nv.start && (st == SN_IDLE))
		begin
			op_q   <= nv.op;
			sec_q  <= nv.sector;
			data_q <= nv.wdata;
		end

	// Cells keep state over hardware reset; only blank init clears them
	always_ff @(posedge clk or negedge nv_init_n)
		if (!nv_init_n)
		begin
			nv.persist <= '1;
			nv.mode    <= `SPC_MODE_BLANK;
			nv.pwd     <= `SPC_PWD_BLANK;
			nv.cfg     <= `SPC_CFG_BLANK;
			nv.learn   <= `SPC_LRN_BLANK;
		end
		else if (st == SN_PREP)
			nv.persist <= '0;
		else if (nv.done)
			case (op_q)
			NV_MODE:  nv.mode <= nv.mode & data_q[1:0];
			NV_PWD:   nv.pwd <= nv.pwd & data_q;
			NV_CFG:
			begin
				nv.cfg   <= nv.cfg & data_q[31:0];
				nv.learn <= nv.learn & data_q[39:32];
			end
			NV_BIT:   nv.persist[sec_q] <= 1'b0;
			NV_ERASE: nv.persist <= '1;
			default:  nv.mode <= nv.mode;
			endcase

	erase_all_a: assert property (@(posedge clk) disable iff (!rstn || !nv_init_n)
		(st == SN_ERASE) && last |=> &nv.persist)
		else $error("erase left a sector bit at zero");
	prep_first_a: assert property (@(posedge clk) disable iff (!rstn || !nv_init_n)
		$rose(st == SN_ERASE) |-> $past(st == SN_PREP) && (nv.persist == '0))
		else $error("erase started without preprogram");
endmodule : spc_nv_store

//--- design/spc_params.svh
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SPC_STATUS_OFS 8'h00
`define SPC_CMD_OFS    8'h04
`define SPC_DLO_OFS    8'h08
`define SPC_DHI_OFS    8'h0C
`define SPC_MODE_OFS   8'h10
`define SPC_LOCK_OFS   8'h14
`define SPC_RES_OFS    8'h18
`define SPC_CFG_OFS    8'h1C
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SPC_BUSY_BIT   0
`define SPC_WEL_BIT    1
`define SPC_PERR_BIT   6
`define SPC_OP_MSB     3
`define SPC_SEC_LSB    8
// ----------------------------------------
// Reset and code values
// ----------------------------------------
`define SPC_MODE_BLANK 2'h3
`define SPC_MODE_PERS  2'h2
`define SPC_MODE_PWD   2'h1
`define SPC_MODE_ILL   2'h0
`define SPC_PWD_BLANK  64'hFFFF_FFFF_FFFF_FFFF
`define SPC_CFG_BLANK  32'hFFFF_FFFF
`define SPC_LRN_BLANK  8'hFF
// ----------------------------------------
// Timing
// ----------------------------------------
`define SPC_CLK_MHZ    50
`define SPC_UNLOCK_US  100
`define SPC_UNLOCK_CYC (`SPC_UNLOCK_US * `SPC_CLK_MHZ)
`define SPC_PROG_CYC   1000
`define SPC_ERASE_CYC  4000
`endif

//--- design/spc_pkg.sv
package spc_pkg;
	// Host commands, low nibble of the command register
	typedef enum logic [3:0] {
		CMD_NONE     = 4'h0,
		CMD_WEN      = 4'h1,
		CMD_MODE     = 4'h2,
		CMD_PWD      = 4'h3,
		CMD_CFG      = 4'h4,
		CMD_BIT_PROG = 4'h5,
		CMD_BIT_ERAS = 4'h6,
		CMD_BIT_READ = 4'h7,
		CMD_VOL_WR   = 4'h8,
		CMD_LOCK_CLR = 4'h9,
		CMD_UNLOCK   = 4'hA,
		CMD_CLR_STAT = 4'hB
	} spc_cmd_t;
	// Operations of the non-volatile store
	typedef enum logic [2:0] {
		NV_MODE  = 3'h0,
		NV_PWD   = 3'h1,
		NV_CFG   = 3'h2,
		NV_BIT   = 3'h3,
		NV_ERASE = 3'h4
	} spc_nvop_t;
	// Control states
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_NV   = 3'h2,
		ST_WAIT = 3'h4
	} spc_st_t;
	// Store states
	typedef enum logic [3:0] {
		SN_IDLE  = 4'h1,
		SN_PROG  = 4'h2,
		SN_PREP  = 4'h4,
		SN_ERASE = 4'h8
	} spc_nst_t;
endpackage : spc_pkg

//--- design/spc_sector_protect.sv
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "spc_params.svh"
// ----------------------------------------
// Sector protection control
// ----------------------------------------
// What this block does
// - Mode field 11 default, 10 boot, 01 password
// - Mode program to 00 fails
// - Blank part: boot mode, all unprotected
// - Chosen mode freezes config, mode, password
// - Busy flag set while mode programs
// - Persistent bit zero blocks its sector
// - Program one bit to 0; erase all
// - Erase preprograms and verifies internally
// - Busy flag shows bit program and erase
// - Lock zero: persistent bit program and erase fail, unchanged
// - Bit read returns addressed persistent bit
// - Volatile bit write: 0 protect, 1 free
// - Protected when either sector bit zero
// - Volatile bits reset; persistent bits kept
// - Lock zero freezes all persistent bits
// - Boot mode: lock set at reset
// - Lock clear final until next reset or good unlock
// - Password mode: lock zero, unlock sets
// - Volatile bits free; persistent need lock
// - Range protection ORed into sector result
// - Wrong password: error, busy, lock unchanged
// - Unlock rate limit; good password fast
module spc_sector_protect
	import spc_pkg::*;
#(
	parameter int NSEC       = 128,
	parameter int SW         = $clog2(NSEC),
	parameter int UNLOCK_CYC = `SPC_UNLOCK_CYC,
	parameter int PROG_CYC   = `SPC_PROG_CYC,
	parameter int ERASE_CYC  = `SPC_ERASE_CYC
)(
	input  wire logic          clk,
	input  wire logic          rstn,
	input  wire logic          nv_init_n,
	input  wire logic [7:0]    addr,
	input  wire logic [31:0]   wdata,
	input  wire logic          wr,
	input  wire logic          rd,
	output logic      [31:0]   rdata,
	input  wire logic          pe_req,
	input  wire logic [SW-1:0] pe_sector,
	input  wire logic          bp_protect,
	output logic               pe_ack,
	output logic               pe_protect
);
	localparam int CW = $clog2(UNLOCK_CYC + 1);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	spc_nv_if #(.NSEC(NSEC), .SW(SW)) nv ();
	spc_st_t         state;        // Control state
	logic [CW-1:0]   wait_cnt;     // Unlock penalty countdown
	logic            program_error;       // Sticky error flag
	logic            fail_hold;    // Busy held by a failure
	logic            write_enable_latch;  // Arms one modifying command
	logic            lock;         // Persistent lock register bit
	logic            lock_init;    // Lock load pending after reset
	logic [NSEC-1:0] vol_bits;     // Volatile sector bits
	logic [NSEC-1:0] prot_vec;     // Per-sector protected
	logic [31:0]     dlo;          // Operand low word
	logic [31:0]     dhi;          // Operand high word
	logic            bit_res;      // Last persistent bit read
	logic [31:0]     rd_val;       // Read mux
	logic            write_in_progress_flag; // Busy status bit
	logic            cmd_wr;       // Write to command register
	spc_cmd_t        cmd_op;       // Command code
	logic [SW-1:0]   cmd_sec;      // Command sector
	logic            accept;       // Command may be looked at
	logic            is_mod;       // Command changes non-volatile data
	logic            cmd_fail;     // Command fails its checks
	logic            take;         // Command executed or failed
	logic            fail;         // Failing command taken
	logic            go_nv;        // Start the store
	logic            good_unlock;  // Correct password given
	logic            bad_unlock;   // Unlock refused
	logic            clr;          // Status clear taken
	logic            mode_chosen;  // Mode bits no longer blank
	logic            pwd_mode;     // Password mode in force
	logic            pwd_match;    // Operand equals password
	spc_nvop_t       nv_op;        // Store operation

	// ----------------------------------------
	// Store
	// ----------------------------------------
	spc_nv_store #(
		.NSEC      (NSEC),
		.SW        (SW),
		.PROG_CYC  (PROG_CYC),
		.ERASE_CYC (ERASE_CYC)
	) u_store (
		.clk       (clk),
		.rstn      (rstn),
		.nv_init_n (nv_init_n),
		.nv        (nv.store)
	);

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	// Blank 11 behaves as boot mode; 00 can never be stored
	assign mode_chosen = (nv.mode != `SPC_MODE_BLANK);
	assign pwd_mode    = (nv.mode == `SPC_MODE_PWD);
	assign pwd_match   = ({dhi, dlo} == nv.pwd);

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	assign cmd_wr  = wr && (addr == `SPC_CMD_OFS);
	assign cmd_op  = spc_cmd_t'(wdata[`SPC_OP_MSB:0]);
	assign cmd_sec = wdata[`SPC_SEC_LSB +: SW];
	// Only status clear is looked at while a failure holds busy; nothing mid store work or penalty, or during the lock load cycle
	assign accept  = cmd_wr && (state == ST_IDLE) && !fail_hold && !lock_init;
	assign is_mod  = (cmd_op == CMD_MODE) || (cmd_op == CMD_PWD) ||
		(cmd_op == CMD_CFG) || (cmd_op == CMD_BIT_PROG) || (cmd_op == CMD_BIT_ERAS);
	// Unarmed modifying commands are dropped silently
	assign take    = accept && (!is_mod || write_enable_latch);
	assign fail    = take && cmd_fail;
	assign go_nv   = take && is_mod && !cmd_fail;
	assign good_unlock = take && (cmd_op == CMD_UNLOCK) && !cmd_fail;
	assign bad_unlock  = fail && (cmd_op == CMD_UNLOCK);
	// Clear is taken even with a failure held, but never mid penalty
	assign clr = cmd_wr && (cmd_op == CMD_CLR_STAT) && (state == ST_IDLE) && !lock_init;

	// Failure checks per command
	always_comb
	begin
		cmd_fail = 1'b0;
		case (cmd_op)
		CMD_MODE:
			cmd_fail = mode_chosen || (dlo[1:0] == `SPC_MODE_ILL);
		CMD_PWD, CMD_CFG:
			cmd_fail = mode_chosen;
		CMD_BIT_PROG, CMD_BIT_ERAS:
			cmd_fail = !lock;
		CMD_UNLOCK:
			cmd_fail = !pwd_mode || !pwd_match;
		default:
			cmd_fail = 1'b0;
		endcase
	end

	// Store operation for each modifying command
	always_comb
	begin
		nv_op = NV_MODE;
		case (cmd_op)
		CMD_PWD:      nv_op = NV_PWD;
		CMD_CFG:      nv_op = NV_CFG;
		CMD_BIT_PROG: nv_op = NV_BIT;
		CMD_BIT_ERAS: nv_op = NV_ERASE;
		default:      nv_op = NV_MODE;
		endcase
	end

	assign nv.start  = go_nv;
	assign nv.op     = nv_op;
	assign nv.sector = cmd_sec;
	assign nv.wdata  = {dhi, dlo};

	// ----------------------------------------
	// Control state
	// ----------------------------------------
	// Wrong password parks the block for the penalty time
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			state    <= ST_IDLE;
			wait_cnt <= '0;
		end
		else
			case (state)
			ST_IDLE:
				if (go_nv)
					state <= ST_NV;
				else if (bad_unlock)
				begin
					state    <= ST_WAIT;
					wait_cnt <= CW'(UNLOCK_CYC - 1);
				end
			ST_NV:
				if (nv.done) state <= ST_IDLE;
			ST_WAIT:
				if (wait_cnt == '0) state <= ST_IDLE;
				else wait_cnt <= wait_cnt - 1'b1;
			default:
				state <= ST_IDLE;
			endcase

	// Busy covers store work, penalty and any held failure
	assign write_in_progress_flag = (state != ST_IDLE) || fail_hold;

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	// Error and held busy; a new failure wins over a clear
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			program_error <= 1'b0;
			fail_hold     <= 1'b0;
		end
		else if (fail)
		begin
			program_error <= 1'b1;
			fail_hold     <= 1'b1;
		end
		else if (clr)
		begin
			program_error <= 1'b0;
			fail_hold     <= 1'b0;
		end

	// Write enable latch arms exactly one modifying command
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			write_enable_latch <= 1'b0;
		else if (take && is_mod)
			write_enable_latch <= 1'b0;
		else if (take && (cmd_op == CMD_WEN))
			write_enable_latch <= 1'b1;

	// ----------------------------------------
	// Lock register
	// ----------------------------------------
	// Reset forces zero; the mode dependent value loads on the
	// first edge after release, since mode is not a constant
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			lock      <= 1'b0;
			lock_init <= 1'b1;
		end
		else if (lock_init)
		begin
			lock      <= !pwd_mode;
			lock_init <= 1'b0;
		end
		else if (good_unlock)
			lock <= 1'b1;
		else if (take && (cmd_op == CMD_LOCK_CLR))
			lock <= 1'b0;

	// ----------------------------------------
	// Volatile sector bits
	// ----------------------------------------
	// Written freely whatever the lock says; lost on reset
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			vol_bits <= '1;
		else if (take && (cmd_op == CMD_VOL_WR))
			vol_bits[cmd_sec] <= dlo[0];

	// Per-sector protection, either bit at zero protects
	genvar gi;
	generate
		for (gi = 0; gi < NSEC; gi++)
		begin : g_prot
			assign prot_vec[gi] = !nv.persist[gi] || !vol_bits[gi];
		end
	endgenerate

	// ----------------------------------------
	// Engine query
	// ----------------------------------------
	// One-cycle answer so the engine checks before touching the array
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			pe_ack     <= 1'b0;
			pe_protect <= 1'b0;
		end
		else
		begin
			pe_ack     <= pe_req;
			pe_protect <= pe_req && (prot_vec[pe_sector] || bp_protect);
		end

	// ----------------------------------------
	// Operands and read result
	// ----------------------------------------
	// Operand words, staged before a command uses them
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			dlo <= '0;
			dhi <= '0;
		end
		else if (wr && (addr == `SPC_DLO_OFS))
			dlo <= wdata;
		else if (wr && (addr == `SPC_DHI_OFS))
			dhi <= wdata;

	// Persistent bit read result
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			bit_res <= 1'b0;
		else if (take && (cmd_op == CMD_BIT_READ))
			bit_res <= nv.persist[cmd_sec];

	// ----------------------------------------
	// Register read
	// ----------------------------------------
	// Password never reads back; unmapped offsets read zero
	always_comb
	begin
		rd_val = '0;
		case (addr)
		`SPC_STATUS_OFS:
		begin
			rd_val[`SPC_BUSY_BIT] = write_in_progress_flag;
			rd_val[`SPC_WEL_BIT]  = write_enable_latch;
			rd_val[`SPC_PERR_BIT] = program_error;
		end
		`SPC_DLO_OFS:  rd_val = dlo;
		`SPC_DHI_OFS:  rd_val = dhi;
		`SPC_MODE_OFS: rd_val[1:0] = nv.mode;
		`SPC_LOCK_OFS: rd_val[0] = lock;
		`SPC_RES_OFS:  rd_val[0] = bit_res;
		`SPC_CFG_OFS:  rd_val = nv.cfg;
		default:       rd_val = '0;
		endcase
	end

	// Data stand only in the cycle after the strobe
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			rdata <= '0;
		else
			rdata <= rd ? rd_val : '0;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	illegal_mode_a: assert property (@(posedge clk) disable iff (!rstn)
		take && (cmd_op == CMD_MODE) && (dlo[1:0] == `SPC_MODE_ILL)
		|=> program_error && (state == ST_IDLE) && write_in_progress_flag)
		else $error("mode 00 was not refused");

	mode_frozen_a: assert property (@(posedge clk) disable iff (!rstn)
		take && mode_chosen && ((cmd_op == CMD_PWD) || (cmd_op == CMD_CFG))
		|=> program_error && !nv.busy)
		else $error("frozen register change not refused");

	store_busy_a: assert property (@(posedge clk) disable iff (!rstn)
		go_nv |=> (write_in_progress_flag && nv.busy) [*2])
		else $error("busy flag dropped during store work");

	bit_locked_a: assert property (@(posedge clk) disable iff (!rstn)
		take && !lock && (cmd_op == CMD_BIT_PROG)
		|=> program_error && !nv.busy && $stable(nv.persist))
		else $error("locked bit command executed");

	lock_rise_a: assert property (@(posedge clk) disable iff (!rstn)
		$rose(lock) |-> $past(lock_init) || $past(good_unlock))
		else $error("lock set by other than reset or unlock");

	vol_write_a: assert property (@(posedge clk) disable iff (!rstn)
		take && (cmd_op == CMD_VOL_WR)
		|=> vol_bits[$past(cmd_sec)] == $past(dlo[0]))
		else $error("volatile bit write lost");

	prot_answer_a: assert property (@(posedge clk) disable iff (!rstn)
		pe_req |=> pe_ack && (pe_protect == ($past(!nv.persist[pe_sector]) ||
			$past(!vol_bits[pe_sector]) || $past(bp_protect))))
		else $error("protection answer wrong");

	bad_pwd_a: assert property (@(posedge clk) disable iff (!rstn)
		bad_unlock |=> (state == ST_WAIT) && program_error && $stable(lock) &&
			write_in_progress_flag)
		else $error("wrong password not handled");

	good_pwd_a: assert property (@(posedge clk) disable iff (!rstn)
		good_unlock |=> lock && !write_in_progress_flag)
		else $error("good password delayed");
endmodule : spc_sector_protect
